// file: core/eacs_pkg.sv
// Constants and types for the extended address command sequencer
package eacs_pkg;
   localparam int UPPER_W = 6;
   localparam int LOW_BLK_W = 32;
   localparam int BLK_W = 38;
   localparam int AU_LOW_W = 22;
   localparam int AU_W = 28;
   localparam int CMD_W = 6;
   localparam int ARG_W = 32;
   localparam int WCNT_W = 64;
   localparam int CRC_W = 16;
   localparam logic [15:0] CRC16_POLY = 16'h1021;
   localparam logic [5:0] CMD_STOP = 6'h0C;
   localparam logic [5:0] CMD_STATUS = 6'h0D;
   localparam logic [5:0] CMD_RD1 = 6'h11;
   localparam logic [5:0] CMD_RDM = 6'h12;
   localparam logic [5:0] CMD_SPEED = 6'h14;
   localparam logic [5:0] CMD_EXT = 6'h16;
   localparam logic [5:0] CMD_CNT = 6'h17;
   localparam logic [5:0] CMD_WR1 = 6'h18;
   localparam logic [5:0] CMD_WRM = 6'h19;
   localparam logic [5:0] CMD_ER_S = 6'h20;
   localparam logic [5:0] CMD_ER_E = 6'h21;
   localparam logic [5:0] CMD_ERASE = 6'h26;
   localparam logic [5:0] ACMD_WCNT = 6'h16;
   localparam logic [5:0] ACMD_PRE = 6'h17;
   localparam int FUNC_LO = 28;
   localparam logic [3:0] FUNC_SET_FREE = 4'h1;
   localparam int ST_RANGE = 31;
   localparam int ST_ADDR = 30;
   localparam int ST_ILL = 22;
   localparam int ST_STATE_LO = 9;
   localparam int SUSP_SPLIT = 6;
   typedef enum logic [3:0] {
      EACS_TRAN = 4'h4,
      EACS_DATA = 4'h5,
      EACS_RCV = 4'h6,
      EACS_PRG = 4'h7
   } eacs_state_t;
endpackage : eacs_pkg

// file: core/eacs_cmd_if.sv
// Command carrier from the link crossing to the sequencer
`timescale 1ns/1ps
`default_nettype none
interface eacs_cmd_if;
   logic valid;
   logic [5:0] index;
   logic [31:0] arg;
   logic app;
   modport src (output valid, output index, output arg, output app);
   modport dst (input valid, input index, input arg, input app);
endinterface : eacs_cmd_if
`default_nettype wire

// file: core/eacs_cmd_cdc.sv
// Toggle crossing of received commands from link clock to system clock
`timescale 1ns/1ps
`default_nettype none
module eacs_cmd_cdc (
   input wire logic clk_link,
   input wire logic link_srst,
   input wire logic cmd_valid,
   input wire logic [5:0] cmd_index,
   input wire logic [31:0] cmd_arg,
   input wire logic cmd_app,
   input wire logic clk_sys,
   input wire logic srst,
   eacs_cmd_if.src c
);
   logic [38:0] hold;
   logic tgl;
   logic s1;
   logic s2;
   logic s3;

   // Held word stays stable for many sys cycles between commands
   always_ff @(posedge clk_link) begin
      if (link_srst) begin
         hold <= 39'h0;
         tgl <= 1'b0;
      end else if (cmd_valid) begin
         hold <= {cmd_app, cmd_index, cmd_arg};
         tgl <= ~tgl;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
      end else begin
         s1 <= tgl;
         s2 <= s1;
         s3 <= s2;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         c.valid <= 1'b0;
         c.app <= 1'b0;
         c.index <= 6'h00;
         c.arg <= 32'h0;
      end else begin
         c.valid <= s2 ^ s3;
         if (s2 ^ s3) begin
            c.app <= hold[38];
            c.index <= hold[37:32];
            c.arg <= hold[31:0];
         end
      end
   end
endmodule : eacs_cmd_cdc
`default_nettype wire

// file: core/eacs_crc16.sv
// Parallel CRC16 over a data word, most significant bit first
`timescale 1ns/1ps
`default_nettype none
module eacs_crc16 import eacs_pkg::*; #(
   parameter int W = WCNT_W
) (
   input wire logic [W-1:0] data,
   output logic [15:0] crc
);
   always_comb begin
      logic fb;
      fb = 1'b0;
      crc = 16'h0000;
      for (int i = W - 1; i >= 0; i--) begin
         fb = crc[15] ^ data[i];
         crc = {crc[14:0], 1'b0} ^ (fb ? CRC16_POLY : 16'h0000);
      end
   end
endmodule : eacs_crc16
`default_nettype wire

// file: core/eacs_top.sv
// Sequencer for extended 38-bit block and 28-bit unit addressing
`timescale 1ns/1ps
`default_nettype none
// Function
// - Extension command latches argument low six bits as upper address.
// - Block read, write, erase addresses are upper six over 32-bit argument.
// - Set free unit address is upper six over 22-bit field.
// - Extension command gets a plain response and never busy.
// - Address and length checked at block command, flagged in its response.
// - Status query leaves sequence and latched upper bits unchanged.
// - Stop discards the sequence; next command starts a new one.
// - Within a sequence, commands outside the set, or wrong speed function, flag address error.
// - Multi-block transfer increments the full 38-bit address each block.
// - Extension and block count raise no error of their own.
// - Erase start and end each take an extension for 38-bit addresses.
// - Erase checks addresses; on error no erase and no long busy.
// - Written count query returns 64-bit count followed by CRC16.
// - Pre-erase count is never run; silent with later illegal, or no error.
// - Set free unit address is first unit; later units by increment.
// - Suspension location split: low 22 bits high, top 6 bits below.
// - Stop accepted in tran, data goes tran, rcv goes prg.
// - Reserved bits of returned words read as zero.
// - Card registers reachable only through their own commands.
module eacs_top import eacs_pkg::*; #(
   parameter bit ACMD23_SILENT = 1'b0
) (
   input wire logic CLK_SYS,
   input wire logic SRST,
   input wire logic CLK_LINK,
   input wire logic LINK_SRST,
   input wire logic CMD_VALID,
   input wire logic [5:0] CMD_INDEX,
   input wire logic [31:0] CMD_ARG,
   input wire logic CMD_APP,
   input wire logic [37:0] CAPACITY_BLOCKS,
   input wire logic [63:0] WRITTEN_COUNT,
   input wire logic BLOCK_DONE,
   input wire logic XFER_DONE,
   input wire logic PROG_DONE,
   input wire logic AU_NEXT,
   input wire logic [27:0] SUSPENSION_LOCATION,
   output logic RESP_VALID,
   output logic [31:0] RESP_STATUS,
   output logic [3:0] CARD_STATE,
   output logic BUSY,
   output logic [37:0] BLOCK_ADDR,
   output logic [37:0] ERASE_START,
   output logic [37:0] ERASE_END,
   output logic ERASE_GO,
   output logic [27:0] ALLOCATION_UNIT_ADDR,
   output logic ALLOCATION_UNIT_VALID,
   output logic [79:0] WCOUNT_BLOCK,
   output logic WCOUNT_VALID,
   output logic [27:0] STATUS_SUSP_FIELD
);
   eacs_cmd_if c ();
   eacs_state_t state;
   logic ext_valid;
   logic [5:0] ext_upper;
   logic cnt_seen;
   logic [31:0] cnt;
   logic start_ok;
   logic end_ok;
   logic pend_ill;
   logic [15:0] wcrc;
   logic std;
   logic is_rd;
   logic is_wr;
   logic is_mem;
   logic sf_func;
   logic seq_act;
   logic e_addr;
   logic e_range;
   logic e_ill;
   logic silent;
   logic [37:0] full_blk;
   logic [27:0] full_au;
   logic [38:0] blk_end;
   logic [31:0] next_status;

   eacs_cmd_cdc u_cdc (
      .clk_link(CLK_LINK),
      .link_srst(LINK_SRST),
      .cmd_valid(CMD_VALID),
      .cmd_index(CMD_INDEX),
      .cmd_arg(CMD_ARG),
      .cmd_app(CMD_APP),
      .clk_sys(CLK_SYS),
      .srst(SRST),
      .c(c)
   );

   eacs_crc16 #(.W(WCNT_W)) u_crc (
      .data(WRITTEN_COUNT),
      .crc(wcrc)
   );

   assign std = c.valid && !c.app;
   assign is_rd = c.index == CMD_RD1 || c.index == CMD_RDM;
   assign is_wr = c.index == CMD_WR1 || c.index == CMD_WRM;
   assign is_mem = is_rd || is_wr;
   assign sf_func = c.arg[FUNC_LO +: 4] == FUNC_SET_FREE;
   assign seq_act = ext_valid || cnt_seen;
   assign full_blk = {ext_upper, c.arg};
   assign full_au = {ext_upper, c.arg[AU_LOW_W-1:0]};
   // Single-block commands always move exactly one block
   assign blk_end = {1'b0, full_blk} +
      ((cnt_seen && (c.index == CMD_RDM || c.index == CMD_WRM)) ?
       {7'h00, cnt} : 39'h1);
   assign CARD_STATE = state;
   assign BUSY = state == EACS_PRG;

   // Own error of the command now arriving
   always_comb begin
      e_addr = 1'b0;
      e_range = 1'b0;
      e_ill = 1'b0;
      silent = 1'b0;
      if (c.app) begin
         if (state != EACS_TRAN) begin
            e_ill = 1'b1;
         end else if (c.index == ACMD_PRE) begin
            silent = ACMD23_SILENT;
         end
      end else if (state != EACS_TRAN && c.index != CMD_STOP &&
                   c.index != CMD_STATUS) begin
         e_ill = 1'b1;
      end else if (state == EACS_PRG && c.index == CMD_STOP) begin
         e_ill = 1'b1;
      end else begin
         case (c.index)
            CMD_RD1, CMD_RDM, CMD_WR1, CMD_WRM: begin
               e_addr = !ext_valid;
               e_range = ext_valid &&
                  blk_end > {1'b0, CAPACITY_BLOCKS};
            end
            CMD_ER_S, CMD_ER_E: begin
               e_addr = !ext_valid;
            end
            CMD_ERASE: begin
               e_addr = !start_ok || !end_ok || ERASE_END < ERASE_START ||
                  ERASE_END >= CAPACITY_BLOCKS;
            end
            CMD_SPEED: begin
               e_addr = seq_act ? !sf_func : sf_func;
            end
            CMD_STOP, CMD_STATUS, CMD_EXT, CMD_CNT: begin
               e_addr = 1'b0;
            end
            default: begin
               e_addr = seq_act;
            end
         endcase
      end
   end

   // Status word; every bit not named stays zero
   always_comb begin
      next_status = 32'h0;
      next_status[ST_RANGE] = e_range;
      next_status[ST_ADDR] = e_addr;
      next_status[ST_ILL] = e_ill || pend_ill;
      next_status[ST_STATE_LO +: 4] = state;
   end

   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         RESP_VALID <= 1'b0;
         RESP_STATUS <= 32'h0;
         pend_ill <= 1'b0;
      end else begin
         RESP_VALID <= c.valid && !silent;
         if (c.valid && silent) begin
            pend_ill <= 1'b1;
         end else if (c.valid) begin
            pend_ill <= 1'b0;
            RESP_STATUS <= next_status;
         end
      end
   end

   // Sequence bookkeeping
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         ext_valid <= 1'b0;
         ext_upper <= 6'h00;
         cnt_seen <= 1'b0;
         cnt <= 32'h0;
      end else if (std && !e_ill) begin
         if (c.index == CMD_STOP) begin
            ext_valid <= 1'b0;
            cnt_seen <= 1'b0;
         end else if (c.index == CMD_EXT) begin
            ext_upper <= c.arg[UPPER_W-1:0];
            ext_valid <= 1'b1;
         end else if (c.index == CMD_CNT) begin
            cnt_seen <= 1'b1;
            cnt <= c.arg;
         end else if (c.index != CMD_STATUS) begin
            ext_valid <= 1'b0;
            if (is_mem) begin
               cnt_seen <= 1'b0;
            end
         end
      end
   end

   // Block address, incremented across the full width
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         BLOCK_ADDR <= 38'h0;
      end else if (std && is_mem && !e_addr && !e_range && !e_ill) begin
         BLOCK_ADDR <= full_blk;
      end else if (BLOCK_DONE &&
                   (state == EACS_DATA || state == EACS_RCV)) begin
         BLOCK_ADDR <= BLOCK_ADDR + 38'h1;
      end
   end

   // Erase range; a failed erase leaves no busy behind
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         ERASE_START <= 38'h0;
         ERASE_END <= 38'h0;
         start_ok <= 1'b0;
         end_ok <= 1'b0;
         ERASE_GO <= 1'b0;
      end else begin
         ERASE_GO <= std && c.index == CMD_ERASE && !e_addr && !e_ill;
         if (std && !e_addr && !e_ill) begin
            if (c.index == CMD_ER_S) begin
               ERASE_START <= full_blk;
               start_ok <= 1'b1;
            end else if (c.index == CMD_ER_E) begin
               ERASE_END <= full_blk;
               end_ok <= 1'b1;
            end
         end
         if (std && c.index == CMD_ERASE) begin
            start_ok <= 1'b0;
            end_ok <= 1'b0;
         end
      end
   end

   // Bundled unit address; later units by increment
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         ALLOCATION_UNIT_ADDR <= 28'h0;
         ALLOCATION_UNIT_VALID <= 1'b0;
      end else begin
         ALLOCATION_UNIT_VALID <= std && c.index == CMD_SPEED && sf_func &&
            !e_addr && !e_ill;
         if (std && c.index == CMD_SPEED && sf_func && !e_addr && !e_ill) begin
            ALLOCATION_UNIT_ADDR <= full_au;
         end else if (AU_NEXT) begin
            ALLOCATION_UNIT_ADDR <= ALLOCATION_UNIT_ADDR + 28'h1;
         end
      end
   end

   // Written count block; only this command reaches it
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         WCOUNT_BLOCK <= 80'h0;
         WCOUNT_VALID <= 1'b0;
      end else begin
         WCOUNT_VALID <= c.valid && c.app && c.index == ACMD_WCNT && !e_ill;
         if (c.valid && c.app && c.index == ACMD_WCNT && !e_ill) begin
            WCOUNT_BLOCK <= {WRITTEN_COUNT, wcrc};
         end
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         STATUS_SUSP_FIELD <= 28'h0;
      end else begin
         STATUS_SUSP_FIELD <= {SUSPENSION_LOCATION[AU_LOW_W-1:0],
            SUSPENSION_LOCATION[AU_W-1:AU_LOW_W]};
      end
   end

   // Card state; a new command wins over completion inputs
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         state <= EACS_TRAN;
      end else if (c.valid && !e_ill && !c.app &&
                   c.index == CMD_STOP) begin
         if (state == EACS_RCV) begin
            state <= EACS_PRG;
         end else begin
            state <= EACS_TRAN;
         end
      end else if (std && is_mem && !e_addr && !e_range && !e_ill) begin
         state <= is_rd ? EACS_DATA : EACS_RCV;
      end else if (ERASE_GO == 1'b0 && std && c.index == CMD_ERASE &&
                   !e_addr && !e_ill) begin
         state <= EACS_PRG;
      end else if (c.valid && c.app && c.index == ACMD_WCNT && !e_ill) begin
         state <= EACS_DATA;
      end else if (XFER_DONE && state == EACS_DATA) begin
         state <= EACS_TRAN;
      end else if (XFER_DONE && state == EACS_RCV) begin
         state <= EACS_PRG;
      end else if (PROG_DONE && state == EACS_PRG) begin
         state <= EACS_TRAN;
      end
   end

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (SRST);

   property p_ext_latch;
      std && c.index == CMD_EXT && state == EACS_TRAN |=>
         ext_valid && ext_upper == $past(c.arg[5:0]);
   endproperty
   a_ext_latch: assert property (p_ext_latch)
      else $error("upper bits not latched");

   property p_blk;
      std && is_mem && !e_addr && !e_range && !e_ill |=>
         BLOCK_ADDR == {$past(ext_upper), $past(c.arg)};
   endproperty
   a_blk: assert property (p_blk)
      else $error("block address wrong");

   property p_au;
      std && c.index == CMD_SPEED && sf_func && !e_addr && !e_ill |=>
         ALLOCATION_UNIT_VALID &&
         ALLOCATION_UNIT_ADDR == {$past(ext_upper), $past(c.arg[21:0])};
   endproperty
   a_au: assert property (p_au)
      else $error("unit address wrong");

   property p_ext_resp;
      std && c.index == CMD_EXT && state == EACS_TRAN |=>
         RESP_VALID && !BUSY && !RESP_STATUS[ST_ADDR];
   endproperty
   a_ext_resp: assert property (p_ext_resp)
      else $error("extension response wrong");

   property p_no_ext;
      std && is_mem && !ext_valid && state == EACS_TRAN |=>
         RESP_STATUS[ST_ADDR] && state == EACS_TRAN;
   endproperty
   a_no_ext: assert property (p_no_ext)
      else $error("missing extension not flagged");

   property p_status;
      std && c.index == CMD_STATUS |=>
         $stable(ext_valid) && $stable(ext_upper) && $stable(cnt_seen);
   endproperty
   a_status: assert property (p_status)
      else $error("status query disturbed sequence");

   property p_stop;
      std && c.index == CMD_STOP && state != EACS_PRG |=>
         !ext_valid && !cnt_seen;
   endproperty
   a_stop: assert property (p_stop)
      else $error("stop did not reset sequence");

   property p_outside;
      std && state == EACS_TRAN && ext_valid && c.index == CMD_SPEED &&
         !sf_func |=> RESP_STATUS[ST_ADDR];
   endproperty
   a_outside: assert property (p_outside)
      else $error("wrong speed function not flagged");

   property p_inc;
      BLOCK_DONE && !c.valid && state == EACS_DATA |=>
         BLOCK_ADDR == $past(BLOCK_ADDR) + 38'h1;
   endproperty
   a_inc: assert property (p_inc)
      else $error("block address not incremented");

   property p_erase;
      std && c.index == CMD_ERASE && state == EACS_TRAN && e_addr |=>
         !ERASE_GO && !BUSY ##1 !ERASE_GO;
   endproperty
   a_erase: assert property (p_erase)
      else $error("erase ran despite error");

   property p_stop_rcv;
      std && c.index == CMD_STOP && state == EACS_RCV |=> state == EACS_PRG;
   endproperty
   a_stop_rcv: assert property (p_stop_rcv)
      else $error("stop in rcv did not go prg");

   c_read: cover property (std && is_rd && !e_addr && !e_range ##1
      state == EACS_DATA);
   c_erase: cover property (ERASE_GO ##1 BUSY);
   c_silent: cover property (c.valid && silent);
endmodule : eacs_top
`default_nettype wire

// file: verification/eacs_host_model.sv
// Host side that issues card bus commands on the link clock
`timescale 1ns/1ps
`default_nettype none
module eacs_host_model (
   input wire logic clk_link,
   output logic cmd_valid,
   output logic [5:0] cmd_index,
   output logic [31:0] cmd_arg,
   output logic cmd_app
);
   initial begin
      cmd_valid = 1'b0;
      cmd_index = 6'h00;
      cmd_arg = 32'h00000000;
      cmd_app = 1'b0;
   end
   // Order of commands is chosen by the caller
   task automatic send(input logic [5:0] i, input logic [31:0] a,
                       input logic ap);
      @(negedge clk_link);
      cmd_valid = 1'b1;
      cmd_index = i;
      cmd_arg = a;
      cmd_app = ap;
      @(negedge clk_link);
      cmd_valid = 1'b0;
      // Released lines show no stale value
      cmd_index = ~i;
      cmd_arg = ~a;
      cmd_app = ~ap;
   endtask : send
endmodule : eacs_host_model
`default_nettype wire

// file: verification/tb.sv
// Self-checking bench for the extended address sequencer
`timescale 1ns/1ps
`default_nettype none
module tb import eacs_pkg::*;;
   logic CLK_SYS = 1'b0, CLK_LINK = 1'b0, SRST = 1'b1, LINK_SRST = 1'b1;
   logic CMD_VALID, CMD_APP;
   logic [5:0] CMD_INDEX;
   logic [31:0] CMD_ARG;
   logic [37:0] CAPACITY_BLOCKS = 38'h3E00000000;
   logic [63:0] WRITTEN_COUNT = 64'h0123456789ABCDEF;
   logic BLOCK_DONE = 1'b0, XFER_DONE = 1'b0, PROG_DONE = 1'b0;
   logic AU_NEXT = 1'b0;
   logic [27:0] SUSPENSION_LOCATION = 28'h0000000;
   logic RESP_VALID, BUSY, ERASE_GO, ALLOCATION_UNIT_VALID, WCOUNT_VALID;
   logic [31:0] RESP_STATUS;
   logic [3:0] CARD_STATE;
   logic [37:0] BLOCK_ADDR, ERASE_START, ERASE_END;
   logic [27:0] ALLOCATION_UNIT_ADDR, STATUS_SUSP_FIELD;
   logic [79:0] WCOUNT_BLOCK, wb;
   logic [31:0] r;
   logic go, av, wv;
   int fails = 0;
   int cmd_count = 0;
   always #5 CLK_SYS = ~CLK_SYS;
   initial begin
      #1.3;
      forever #3 CLK_LINK = ~CLK_LINK;
   end
   eacs_host_model host (.clk_link(CLK_LINK), .cmd_valid(CMD_VALID),
      .cmd_index(CMD_INDEX), .cmd_arg(CMD_ARG), .cmd_app(CMD_APP));
   eacs_top dut (.CLK_SYS(CLK_SYS), .SRST(SRST), .CLK_LINK(CLK_LINK),
      .LINK_SRST(LINK_SRST), .CMD_VALID(CMD_VALID),
      .CMD_INDEX(CMD_INDEX), .CMD_ARG(CMD_ARG), .CMD_APP(CMD_APP),
      .CAPACITY_BLOCKS(CAPACITY_BLOCKS), .WRITTEN_COUNT(WRITTEN_COUNT),
      .BLOCK_DONE(BLOCK_DONE), .XFER_DONE(XFER_DONE),
      .PROG_DONE(PROG_DONE), .AU_NEXT(AU_NEXT),
      .SUSPENSION_LOCATION(SUSPENSION_LOCATION),
      .RESP_VALID(RESP_VALID), .RESP_STATUS(RESP_STATUS),
      .CARD_STATE(CARD_STATE), .BUSY(BUSY), .BLOCK_ADDR(BLOCK_ADDR),
      .ERASE_START(ERASE_START), .ERASE_END(ERASE_END),
      .ERASE_GO(ERASE_GO), .ALLOCATION_UNIT_ADDR(ALLOCATION_UNIT_ADDR),
      .ALLOCATION_UNIT_VALID(ALLOCATION_UNIT_VALID),
      .WCOUNT_BLOCK(WCOUNT_BLOCK), .WCOUNT_VALID(WCOUNT_VALID),
      .STATUS_SUSP_FIELD(STATUS_SUSP_FIELD));
   task automatic chk(input string n, input logic [79:0] s,
                      input logic [79:0] e);
      cmd_count++;
      if (s !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   function automatic logic [2:0] err(input logic [31:0] v);
      return {v[ST_RANGE], v[ST_ADDR], v[ST_ILL]};
   endfunction : err
   // Own bitwise model, MSB first, zero start
   function automatic logic [15:0] crc(input logic [63:0] d);
      logic [15:0] c;
      c = 16'h0000;
      for (int i = 63; i >= 0; i--) begin
         c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? CRC16_POLY : 16'h0000);
      end
      return c;
   endfunction : crc
   task automatic cmd(input logic [5:0] i, input logic [31:0] a,
                      input logic ap);
      int n;
      n = 0;
      host.send(i, a, ap);
      while (RESP_VALID !== 1'b1 && n < 60) begin
         @(negedge CLK_SYS);
         n++;
      end
      chk("resp_valid", RESP_VALID, 1'b1);
      r = RESP_STATUS;
      go = ERASE_GO;
      av = ALLOCATION_UNIT_VALID;
      wv = WCOUNT_VALID;
      wb = WCOUNT_BLOCK;
      chk("reserved", r & ~32'hC0401E00, 32'h0);
      // Spacing keeps the crossing from dropping commands
      repeat (10) @(negedge CLK_SYS);
   endtask : cmd
   task automatic step(input int k);
      @(negedge CLK_SYS);
      case (k)
         0: BLOCK_DONE = 1'b1;
         1: XFER_DONE = 1'b1;
         2: PROG_DONE = 1'b1;
         default: AU_NEXT = 1'b1;
      endcase
      @(negedge CLK_SYS);
      {BLOCK_DONE, XFER_DONE, PROG_DONE, AU_NEXT} = 4'h0;
      @(negedge CLK_SYS);
   endtask : step
   task automatic t_read;
      cmd(CMD_EXT, 32'hFFFFFFC0, 1'b0);
      chk("ext_err", err(r), 3'b000);
      chk("ext_state", r[12:9], EACS_TRAN);
      chk("ext_busy", BUSY, 1'b0);
      cmd(CMD_STATUS, 32'h0, 1'b0);
      cmd(CMD_RDM, 32'hFFFFFFFF, 1'b0);
      chk("rd_err", err(r), 3'b000);
      chk("rd_addr", BLOCK_ADDR, 38'h00FFFFFFFF);
      chk("rd_state", CARD_STATE, EACS_DATA);
      step(0);
      chk("rd_cross", BLOCK_ADDR, 38'h0100000000);
      step(1);
      chk("rd_tran", CARD_STATE, EACS_TRAN);
      cmd(CMD_EXT, 32'h0000002A, 1'b0);
      cmd(CMD_WRM, 32'h00000005, 1'b0);
      chk("wr_addr", BLOCK_ADDR, 38'h2A00000005);
      chk("wr_state", CARD_STATE, EACS_RCV);
      cmd(CMD_STOP, 32'h0, 1'b0);
      chk("stop_prg", CARD_STATE, EACS_PRG);
      step(2);
      chk("prg_tran", CARD_STATE, EACS_TRAN);
      $display("Test read and write done");
   endtask : t_read
   task automatic t_err;
      cmd(CMD_EXT, 32'h0000003F, 1'b0);
      cmd(CMD_RD1, 32'h00000000, 1'b0);
      chk("range_err", err(r), 3'b100);
      chk("range_addr", BLOCK_ADDR, 38'h2A00000005);
      cmd(CMD_EXT, 32'h00000001, 1'b0);
      cmd(6'h06, 32'h0, 1'b0);
      chk("unk_err", err(r), 3'b010);
      cmd(CMD_STOP, 32'h0, 1'b0);
      chk("stop_tran", err(r), 3'b000);
      chk("stop_state", CARD_STATE, EACS_TRAN);
      cmd(6'h06, 32'h0, 1'b0);
      chk("new_seq", err(r), 3'b000);
      cmd(CMD_RD1, 32'h00000000, 1'b0);
      chk("no_ext", err(r), 3'b010);
      chk("no_ext_state", CARD_STATE, EACS_TRAN);
      cmd(CMD_EXT, 32'h00000000, 1'b0);
      cmd(CMD_SPEED, 32'h20000000, 1'b0);
      chk("func_err", err(r), 3'b010);
      cmd(CMD_STOP, 32'h0, 1'b0);
      // Count ahead of extension; range end lands exactly on capacity
      cmd(CMD_CNT, 32'h00000008, 1'b0);
      chk("cnt_err", err(r), 3'b000);
      cmd(CMD_EXT, 32'h0000003D, 1'b0);
      cmd(CMD_STATUS, 32'h0, 1'b0);
      cmd(CMD_RDM, 32'hFFFFFFF8, 1'b0);
      chk("cnt_ok", err(r), 3'b000);
      chk("cnt_addr", BLOCK_ADDR, 38'h3DFFFFFFF8);
      step(1);
      cmd(CMD_CNT, 32'h00000009, 1'b0);
      cmd(CMD_EXT, 32'h0000003D, 1'b0);
      cmd(CMD_RDM, 32'hFFFFFFF8, 1'b0);
      chk("cnt_range", err(r), 3'b100);
      chk("cnt_state", CARD_STATE, EACS_TRAN);
      $display("Test errors done");
   endtask : t_err
   task automatic t_erase;
      cmd(CMD_EXT, 32'h00000001, 1'b0);
      cmd(CMD_ER_S, 32'h0000000A, 1'b0);
      cmd(CMD_EXT, 32'h00000001, 1'b0);
      cmd(CMD_ER_E, 32'h00000014, 1'b0);
      cmd(CMD_ERASE, 32'h0, 1'b0);
      chk("er_go", go, 1'b1);
      chk("er_err", err(r), 3'b000);
      chk("er_start", ERASE_START, 38'h010000000A);
      chk("er_end", ERASE_END, 38'h0100000014);
      chk("er_busy", BUSY, 1'b1);
      cmd(CMD_STOP, 32'h0, 1'b0);
      chk("prg_stop", err(r), 3'b001);
      chk("prg_stay", CARD_STATE, EACS_PRG);
      step(2);
      chk("er_tran", CARD_STATE, EACS_TRAN);
      cmd(CMD_EXT, 32'h0, 1'b0);
      cmd(CMD_ER_S, 32'h00000014, 1'b0);
      cmd(CMD_EXT, 32'h0, 1'b0);
      cmd(CMD_ER_E, 32'h0000000A, 1'b0);
      cmd(CMD_ERASE, 32'h0, 1'b0);
      chk("bad_err", err(r), 3'b010);
      chk("bad_go", go, 1'b0);
      chk("bad_busy", BUSY, 1'b0);
      $display("Test erase done");
   endtask : t_erase
   task automatic t_free;
      cmd(CMD_EXT, 32'h00000001, 1'b0);
      cmd(CMD_SPEED, 32'h103FFFFF, 1'b0);
      chk("au_err", err(r), 3'b000);
      chk("au_valid", av, 1'b1);
      chk("au_addr", ALLOCATION_UNIT_ADDR, 28'h07FFFFF);
      step(3);
      chk("au_next", ALLOCATION_UNIT_ADDR, 28'h0800000);
      $display("Test set free done");
   endtask : t_free
   task automatic t_app;
      cmd(ACMD_WCNT, 32'h0, 1'b1);
      chk("wc_valid", wv, 1'b1);
      chk("wc_block", wb, {WRITTEN_COUNT, crc(WRITTEN_COUNT)});
      chk("wc_state", CARD_STATE, EACS_DATA);
      cmd(CMD_EXT, 32'h00000001, 1'b0);
      chk("ill_err", err(r), 3'b001);
      chk("ill_state", CARD_STATE, EACS_DATA);
      step(1);
      cmd(ACMD_PRE, 32'h0, 1'b1);
      chk("pre_err", err(r), 3'b000);
      chk("pre_state", CARD_STATE, EACS_TRAN);
      @(negedge CLK_SYS);
      SUSPENSION_LOCATION = 28'hABCDEF1;
      repeat (3) @(negedge CLK_SYS);
      chk("susp", STATUS_SUSP_FIELD, 28'hF37BC6A);
      $display("Test app and status done");
   endtask : t_app
   task automatic wrap_up;
      $display("Checks %0d mismatches %0d", cmd_count, fails);
      if (fails == 0 && cmd_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : wrap_up
   initial begin
      // About 40 commands of about 15 cycles each, with a wide margin
      #200us;
      fails++;
      wrap_up();
   end
   initial begin
      repeat (12) @(negedge CLK_SYS);
      SRST = 1'b0;
      LINK_SRST = 1'b0;
      repeat (4) @(negedge CLK_SYS);
      t_read();
      t_err();
      t_erase();
      t_free();
      t_app();
      wrap_up();
   end
endmodule : tb
`default_nettype wire
